// *** hdl/ebh_pkg.sv ***
// package for the external bus handover block
package ebh_pkg;
   localparam int EBH_AW = 14;   // address bus width
   localparam int EBH_DW = 24;   // data bus width
   localparam int EBH_NSEL = 5;  // memory select strobes

   // processor-side bus drive request bundle
   typedef struct packed {
      logic [EBH_AW-1:0] addr;
      logic [EBH_DW-1:0] wdata;
      logic              wr_en;      // drive data bus (write)
      logic [EBH_NSEL-1:0] sel_n;    // pm, dm, byte, io, composite
      logic              rd_n;
      logic              wr_n;
   } ebh_bus_t;

   localparam ebh_bus_t EBH_BUS_IDLE = '{
      addr:  '0,
      wdata: '0,
      wr_en: 1'b0,
      sel_n: {EBH_NSEL{1'b1}},
      rd_n:  1'b1,
      wr_n:  1'b1};

   // handover states, gray along own -> granted -> (hung); hung -> own flips both bits
   typedef enum logic [1:0] {
      EBH_OWN   = 2'b00,
      EBH_GRANT = 2'b01,
      EBH_HANG  = 2'b11
   } ebh_state_t;
endpackage

// *** hdl/ebh_handover.sv ***
// external bus handover: request/grant arbitration of the memory bus
`timescale 1ns/1ps
`default_nettype none

module ebh_handover (
   // clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        arst_n,
   // processor core side
   input  wire logic                        run_until_ext,
   input  wire logic                        core_ext_req,
   input  wire ebh_pkg::ebh_bus_t           core_bus,
   input  wire logic                        core_ext_last,
   output logic                             core_stall,
   output logic                             core_reset_n,
   // emulator control
   input  wire logic                        emulator_enable_in,
   input  wire logic                        emu_reset_in_n,
   input  wire logic                        emu_bus_request_n,
   input  wire logic                        emu_single_step,
   input  wire logic                        emu_halted,
   output logic                             emu_bus_grant_n,
   output logic                             emu_bus_grant_oe_n,
   // target pins
   input  wire logic                        target_reset_n,
   input  wire logic                        ext_bus_request_n,
   output logic                             ext_bus_grant_n,
   output logic                             ext_bus_grant_oe_n,
   output logic                             grant_hang_indicator_n,
   // external memory bus pins
   output ebh_pkg::ebh_bus_t                mem_bus,
   output logic                             mem_bus_oe_n
);
   import ebh_pkg::*;

   ebh_state_t st_r, st_nxt;
   logic       req_sync_r;       // registered request, active high
   logic       emu_r;            // registered emulator enable
   logic       access_active_r;  // an external access is in flight
   ebh_bus_t   mem_bus_r;
   logic       grant_r;
   logic       hang_r;

   // request source select; target pins ignored in step or halt
   wire logic emu_quiet  = emulator_enable_in &
                           (emu_single_step | emu_halted);
   wire logic req_raw    = emulator_enable_in ? ~emu_bus_request_n
                                              : ~ext_bus_request_n;
   wire logic tgt_rst    = ~target_reset_n & ~emu_quiet;
   wire logic rst_raw    = emulator_enable_in ? ~emu_reset_in_n
                                              : tgt_rst;

   // core reset just passes the chosen source; arbitration ignores it
   assign core_reset_n = ~rst_raw;

   // synchronise request; async input would otherwise race the fsm
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_sync_r <= 1'b0;
         emu_r      <= 1'b0;
      end else begin
         req_sync_r <= req_raw & ~(emulator_enable_in & emu_quiet);
         emu_r      <= emulator_enable_in;
      end
   end

   // an access in flight blocks the grant until its last cycle is done
   wire logic access_now = core_ext_req & ~core_stall;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         access_active_r <= 1'b0;
      else
         access_active_r <= access_now & ~core_ext_last;
   end

   // handover state machine
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         EBH_OWN:
            if (req_sync_r && !access_active_r)
               st_nxt = EBH_GRANT;
         EBH_GRANT:
            if (!req_sync_r)
               st_nxt = EBH_OWN;
            else if (core_ext_req || !run_until_ext)
               st_nxt = EBH_HANG;
         EBH_HANG:
            if (!req_sync_r)
               st_nxt = EBH_OWN;
         default:
            st_nxt = EBH_OWN;
      endcase
   end

   // hang only marks a core that wants the bus, not a plain halt
   wire logic hang_nxt = (st_nxt == EBH_HANG) & core_ext_req;
   wire logic grant_nxt = (st_nxt != EBH_OWN);

   // stall: halted in grant without go mode, or blocked on an access;
   // also held in the cycle the grant is decided, so that no access
   // starts there and is then lost behind the idle bus value
   assign core_stall = (grant_nxt | (st_r != EBH_OWN)) &
                       (~run_until_ext | core_ext_req);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r      <= EBH_OWN;
         grant_r   <= 1'b0;
         hang_r    <= 1'b0;
         mem_bus_r <= EBH_BUS_IDLE;
      end else begin
         st_r      <= st_nxt;
         grant_r   <= grant_nxt;
         hang_r    <= hang_nxt;
         mem_bus_r <= (grant_nxt || core_stall) ? EBH_BUS_IDLE
                                                : core_bus;
      end
   end

   // pin drive: grant floats the memory bus; strobes kept idle meanwhile
   assign mem_bus      = mem_bus_r;
   assign mem_bus_oe_n = grant_r;
   assign ext_bus_grant_n    = ~(grant_r & ~emu_r);
   assign ext_bus_grant_oe_n = emu_r;
   assign emu_bus_grant_n    = ~(grant_r & emu_r);
   assign emu_bus_grant_oe_n = ~emu_r;
   assign grant_hang_indicator_n = ~hang_r;

   // grant appears the cycle after the registered request, if idle
   property p_grant_follows;
      @(posedge ref_clk) disable iff (!arst_n)
      (st_r == EBH_OWN && req_sync_r && !access_active_r)
         |=> (grant_r && mem_bus_oe_n);
   endproperty
   a_grant_follows: assert property (p_grant_follows)
      else $error("grant not given after idle request");

   property p_stall_on_grant;
      @(posedge ref_clk) disable iff (!arst_n)
      (grant_r && !run_until_ext) |-> core_stall;
   endproperty
   a_stall_on_grant: assert property (p_stall_on_grant)
      else $error("core runs while bus granted");

   property p_go_runs;
      @(posedge ref_clk) disable iff (!arst_n)
      (run_until_ext && !core_ext_req) |-> !core_stall;
   endproperty
   a_go_runs: assert property (p_go_runs)
      else $error("go mode stalled without external access");

   property p_wait_access;
      @(posedge ref_clk) disable iff (!arst_n)
      (access_active_r && !grant_r) |=> !grant_r;
   endproperty
   a_wait_access: assert property (p_wait_access)
      else $error("grant during external access");

   // the decision cycle must not launch an access that the grant cuts off
   property p_no_lost_access;
      @(posedge ref_clk) disable iff (!arst_n)
      (st_r == EBH_OWN && st_nxt == EBH_GRANT) |=> !access_active_r;
   endproperty
   a_no_lost_access: assert property (p_no_lost_access)
      else $error("access started in the grant cycle");

   property p_release;
      @(posedge ref_clk) disable iff (!arst_n)
      (grant_r && !req_sync_r) |=> (!grant_r && !mem_bus_oe_n);
   endproperty
   a_release: assert property (p_release)
      else $error("grant kept after request released");

   property p_reset_indep;
      @(posedge ref_clk) disable iff (!arst_n)
      (!core_reset_n && req_sync_r && !access_active_r &&
       st_r == EBH_OWN) |=> grant_r;
   endproperty
   a_reset_indep: assert property (p_reset_indep)
      else $error("request refused during reset");

   property p_hang_needs_grant;
      @(posedge ref_clk) disable iff (!arst_n)
      !grant_hang_indicator_n |-> grant_r;
   endproperty
   a_hang_needs_grant: assert property (p_hang_needs_grant)
      else $error("hang without grant");

   property p_emu_float;
      @(posedge ref_clk) disable iff (!arst_n)
      emu_r |-> (ext_bus_grant_oe_n && !emu_bus_grant_oe_n);
   endproperty
   a_emu_float: assert property (p_emu_float)
      else $error("normal grant driven under emulation");

   property p_sync;
      @(posedge ref_clk) disable iff (!arst_n)
      (!emulator_enable_in && !ext_bus_request_n) |=> req_sync_r;
   endproperty
   a_sync: assert property (p_sync)
      else $error("request not registered");

   c_grant:   cover property (@(posedge ref_clk) disable iff (!arst_n)
                 $rose(grant_r));
   c_hang:    cover property (@(posedge ref_clk) disable iff (!arst_n)
                 $fell(grant_hang_indicator_n));
   c_delayed: cover property (@(posedge ref_clk) disable iff (!arst_n)
                 access_active_r && req_sync_r ##[1:4] grant_r);
   c_emu:     cover property (@(posedge ref_clk) disable iff (!arst_n)
                 emu_r && grant_r);
endmodule
`default_nettype wire

// *** tb/ebh_master_model.sv ***
// far-side bus master model: asks for the bus, uses it only when granted
`timescale 1ns/1ps
`default_nettype none
module ebh_master_model (
   // bench command
   input  wire logic want_bus,
   // device pins
   input  wire logic ext_bus_grant_n,
   output logic      ext_bus_request_n,
   // master's own bus drive
   output logic      bus_driving
);
   // request held low for as long as the bus is wanted, released to return it
   assign ext_bus_request_n = ~want_bus;
   // never drives before grant, so no contention with the device's drivers
   assign bus_driving = want_bus & ~ext_bus_grant_n;
endmodule
`default_nettype wire

// *** tb/test_external_bus_handover.sv ***
// testbench for the external bus handover block
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_handover;
   import ebh_pkg::*;
   logic ref_clk = 0, arst_n = 0, run_until_ext = 0, core_ext_req = 0;
   logic core_ext_last = 0, emulator_enable_in = 0, emu_reset_in_n = 1;
   logic emu_bus_request_n = 1, emu_single_step = 0, emu_halted = 0;
   logic target_reset_n = 1, want_bus = 0, core_stall, core_reset_n;
   logic emu_bus_grant_n, emu_bus_grant_oe_n, ext_bus_request_n;
   logic ext_bus_grant_n, ext_bus_grant_oe_n, grant_hang_indicator_n;
   logic mem_bus_oe_n, bus_driving;
   ebh_bus_t core_bus = '{addr: 14'h1a5, wdata: 24'h3c5a5a, wr_en: 1'b1,
                          sel_n: 5'h1e, rd_n: 1'b1, wr_n: 1'b0};
   ebh_bus_t mem_bus;
   int       n_errors = 0, check_count = 0, n;

   always #10 ref_clk = ~ref_clk;

   ebh_handover uut (.ref_clk(ref_clk), .arst_n(arst_n),
      .run_until_ext(run_until_ext), .core_ext_req(core_ext_req),
      .core_bus(core_bus), .core_ext_last(core_ext_last),
      .core_stall(core_stall), .core_reset_n(core_reset_n),
      .emulator_enable_in(emulator_enable_in),
      .emu_reset_in_n(emu_reset_in_n), .emu_bus_request_n(emu_bus_request_n),
      .emu_single_step(emu_single_step), .emu_halted(emu_halted),
      .emu_bus_grant_n(emu_bus_grant_n),
      .emu_bus_grant_oe_n(emu_bus_grant_oe_n),
      .target_reset_n(target_reset_n), .ext_bus_request_n(ext_bus_request_n),
      .ext_bus_grant_n(ext_bus_grant_n),
      .ext_bus_grant_oe_n(ext_bus_grant_oe_n),
      .grant_hang_indicator_n(grant_hang_indicator_n),
      .mem_bus(mem_bus), .mem_bus_oe_n(mem_bus_oe_n));

   ebh_master_model master (.want_bus(want_bus),
      .ext_bus_grant_n(ext_bus_grant_n),
      .ext_bus_request_n(ext_bus_request_n), .bus_driving(bus_driving));

   task automatic chk(input string nm, input logic [63:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   // bounded wait for grant to reach a level; counts edges taken
   task automatic wait_grant(input logic lvl, output int c);
      c = 0;
      while (ext_bus_grant_n !== lvl && c < 8) begin
         tick(1);
         c++;
      end
   endtask

   // release request and see the bus come back two edges later
   task automatic give_back;
      @(posedge ref_clk);
      want_bus <= 1'b0;
      wait_grant(1'b1, n);
      chk("release_delay", n, 2);
      chk("bus_driven", mem_bus_oe_n, 0);
      chk("hang_off", grant_hang_indicator_n, 1);
      chk("resume", core_stall, 0);
      chk("master_off", bus_driving, 0);
   endtask

   task automatic s_plain;
      @(posedge ref_clk);
      want_bus <= 1'b1;
      wait_grant(1'b0, n);
      chk("grant_delay", n, 2);
      chk("bus_float", mem_bus_oe_n, 1);
      chk("bus_idle", mem_bus, EBH_BUS_IDLE);
      chk("halted", core_stall, 1);
      chk("hang_idle", grant_hang_indicator_n, 1);
      chk("master_drive", bus_driving, 1);
      @(posedge ref_clk);
      core_ext_req <= 1'b1;
      tick(2);
      chk("hang_on", grant_hang_indicator_n, 0);
      give_back;
      @(posedge ref_clk);
      core_ext_req <= 1'b0;
      #1;
      chk("bus_back", mem_bus, core_bus);
   endtask

   // go mode keeps running until an external access is needed
   task automatic s_go;
      @(posedge ref_clk);
      run_until_ext <= 1'b1;
      want_bus <= 1'b1;
      wait_grant(1'b0, n);
      chk("go_running", core_stall, 0);
      @(posedge ref_clk);
      core_ext_req <= 1'b1;
      #1;
      chk("go_stall", core_stall, 1);
      give_back;
      @(posedge ref_clk);
      core_ext_req <= 1'b0;
      run_until_ext <= 1'b0;
   endtask

   // request lands mid-access; grant waits, then falls between accesses
   task automatic s_busy;
      @(posedge ref_clk);
      core_ext_req <= 1'b1;
      want_bus <= 1'b1;
      tick(4);
      chk("defer", ext_bus_grant_n, 1);
      @(posedge ref_clk);
      core_ext_last <= 1'b1;
      @(posedge ref_clk);
      core_ext_last <= 1'b0;
      wait_grant(1'b0, n);
      chk("after_access", n, 1);
      tick(1);
      chk("second_hang", grant_hang_indicator_n, 0);
      give_back;
      @(posedge ref_clk);
      core_ext_req <= 1'b0;
   endtask

   task automatic s_reset;
      @(posedge ref_clk);
      target_reset_n <= 1'b0;
      want_bus <= 1'b1;
      wait_grant(1'b0, n);
      chk("grant_in_reset", n, 2);
      chk("reset_pass", core_reset_n, 0);
      give_back;
      @(posedge ref_clk);
      target_reset_n <= 1'b1;
   endtask

   // emulation: alternate pins, normal grant floated, target ignored
   task automatic s_emu;
      @(posedge ref_clk);
      emulator_enable_in <= 1'b1;
      emu_reset_in_n <= 1'b0;
      tick(3);
      chk("grant_float", ext_bus_grant_oe_n, 1);
      chk("emu_grant_on", emu_bus_grant_oe_n, 0);
      chk("emu_reset", core_reset_n, 0);
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         emu_reset_in_n <= 1'b1;
         emu_single_step <= (i == 0);
         emu_halted <= (i == 1);
         target_reset_n <= 1'b0;
         want_bus <= 1'b1;
         emu_bus_request_n <= 1'b0;
         tick(4);
         chk("ignore_req", emu_bus_grant_n, 1);
         chk("ignore_rst", core_reset_n, 1);
      end
      @(posedge ref_clk);
      {want_bus, emu_halted, emu_bus_request_n} <= 3'h0;
      target_reset_n <= 1'b1;
      tick(3);
      chk("emu_grant", emu_bus_grant_n, 0);
      chk("tgt_grant_off", ext_bus_grant_n, 1);
      @(posedge ref_clk);
      emu_bus_request_n <= 1'b1;
      tick(3);
      chk("emu_release", emu_bus_grant_n, 1);
      @(posedge ref_clk);
      emulator_enable_in <= 1'b0;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // scenarios take under a hundred cycles; the watchdog allows 5000
   initial begin
      #100000;
      n_errors++;
      tally_and_finish;
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      s_plain;
      s_go;
      s_busy;
      s_reset;
      s_emu;
      tally_and_finish;
   end
endmodule
`default_nettype wire
